// File: reference_select_gate_generator.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "gate_gen_regs.svh"
// Notes on behaviour
// - Select high: internal path on, internal 10 MHz used as timebase.
// - Select low: internal path and rear driver off, external reference used.
// - Reference driven outward on the shared line only in internal mode.
// - Selected reference forwarded as converter clock output.
// - Two decade stages divide reference by 100 to 100 kHz.
// - Gate length selectable in decades, 100 us to 1 s.
// - Codes 1..5 select 10 to 100000 periods of 100 kHz.
// - Gate flop enabled by divider and control flops, clocked by 100 kHz.
// - While idle with arm clear, divider runs freely.
// - Setting arm clears sync flop and resets divider.
// - First 100 kHz tick after arming puts gate flop in closed state.
// - Controller pulses arm clear; next tick sets sync flop.
// - Following tick opens gate; divider starts counting.
// - Divider terminal output high after half the interval.
// - At full count terminal low, arm set, sync cleared, close pending.
// - Next tick closes gate; length equals selected period count.
// - Gate and 100 kHz clock delivered to count chain.
module reference_select_gate_generator #(
  parameter int CNT_W = 17
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference inputs, sampled in pclk domain
  input wire logic internal_ref,
  input wire logic reference_io_line_in,
  // Reference line and path enables
  output logic reference_io_line_out,
  output logic reference_io_line_oe,
  output logic internal_path_en,
  output logic external_path_en,
  // Clocks and gate to converter and count chain
  output logic converter_clock_output,
  output logic chain_ref_100k,
  output logic chain_gate
);
  import gate_gen_pkg::*;

  function automatic logic [CNT_W-1:0] ratio_of(input gate_code_t code);
    case (code)
      3'h1: ratio_of = CNT_W'(`GT_RATIO_1);
      3'h2: ratio_of = CNT_W'(`GT_RATIO_2);
      3'h3: ratio_of = CNT_W'(`GT_RATIO_3);
      3'h4: ratio_of = CNT_W'(`GT_RATIO_4);
      3'h5: ratio_of = CNT_W'(`GT_RATIO_5);
      default: ratio_of = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic ref_select;
  gate_code_t gate_code;
  logic gate_arm_flop;
  logic gate_sync_flop;
  logic gate_output_flop;
  logic gate_done;
  logic [CNT_W-1:0] gate_time_divider;
  logic term_out;
  logic int_q;
  logic ext_q;
  logic ref_q;
  gate_state_t state;
  tick_if ticks ();

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && !pwrite;
  wire hit_ctrl = paddr == `ADDR_CTRL;
  wire hit_status = paddr == `ADDR_STATUS;
  wire hit_any = hit_ctrl || hit_status;
  wire arm_set_req = wr_en && hit_ctrl && pwdata[`CTRL_ARM_SET_BIT];
  wire arm_clr_req = wr_en && hit_ctrl && pwdata[`CTRL_ARM_CLR_BIT];
  wire tick = ticks.tick_100k;
  wire code_ok = gate_code >= `GT_CODE_MIN && gate_code <= `GT_CODE_MAX;
  wire [CNT_W-1:0] ratio = ratio_of(gate_code);
  wire [CNT_W-1:0] half = ratio >> 1;
  wire at_end = gate_time_divider == ratio - CNT_W'(1);
  wire sel_ref = ref_select ? int_q : ext_q;
  wire ref_edge = sel_ref && !ref_q;
  wire [31:0] status_word = {27'h0, gate_done, term_out, gate_sync_flop, gate_arm_flop,
                             gate_output_flop};
  wire [31:0] ctrl_word = {25'h0, gate_code, 3'h0, ref_select};

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, zero wait states; unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (rd_en && hit_ctrl) ? ctrl_word :
                (rd_en && hit_status) ? status_word : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_select <= `CTRL_SEL_RESET;
      gate_code <= `CTRL_GT_RESET;
    end else if (wr_en && hit_ctrl && pready) begin
      ref_select <= pwdata[`CTRL_SEL_BIT];
      gate_code <= pwdata[`CTRL_GT_MSB:`CTRL_GT_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference selection and edge detect; samples are plain pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
      ext_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      int_q <= internal_ref;
      ext_q <= reference_io_line_in;
      ref_q <= sel_ref;
    end
  end

  reference_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .ref_edge(ref_edge),
    .ticks(ticks)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_path_en <= 1'b1;
      external_path_en <= 1'b0;
      reference_io_line_oe <= 1'b0;
      reference_io_line_out <= 1'b0;
      converter_clock_output <= 1'b0;
      chain_ref_100k <= 1'b0;
    end else begin
      internal_path_en <= ref_select;
      external_path_en <= !ref_select;
      reference_io_line_oe <= ref_select;
      reference_io_line_out <= ref_select && int_q;
      converter_clock_output <= sel_ref;
      chain_ref_100k <= tick;
    end
  end

  // Path enables follow the select one cycle late
  property p_internal_paths;
    @(posedge pclk) disable iff (!presetn)
      ref_select |=> internal_path_en && !external_path_en && reference_io_line_oe;
  endproperty
  a_internal_paths: assert property (p_internal_paths)
    else $error("internal mode path enables wrong");
  property p_external_paths;
    @(posedge pclk) disable iff (!presetn)
      !ref_select |=> !internal_path_en && external_path_en && !reference_io_line_oe &&
                      !reference_io_line_out;
  endproperty
  a_external_paths: assert property (p_external_paths)
    else $error("external mode path enables or line drive wrong");
  property p_tick_on_edge;
    @(posedge pclk) disable iff (!presetn)
      ticks.tick_100k |-> ticks.tick_10m;
  endproperty
  a_tick_on_edge: assert property (p_tick_on_edge)
    else $error("100 kHz tick without a reference edge");
  property p_chain_ref;
    @(posedge pclk) disable iff (!presetn)
      tick |=> chain_ref_100k;
  endproperty
  a_chain_ref: assert property (p_chain_ref)
    else $error("100 kHz tick not passed to count chain");

  ////////////////////////////////////////////////////////////////////////////
  // Gate sequencer; all changes happen on 100 kHz ticks except arm writes and the gate close on an invalid code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_FREE;
      gate_arm_flop <= 1'b0;
      gate_sync_flop <= 1'b0;
      gate_output_flop <= 1'b0;
      gate_done <= 1'b0;
      gate_time_divider <= '0;
      term_out <= 1'b0;
    end else begin
      case (state)
        ST_FREE: begin
          // Free-runs only with arm clear; a set arm holds the divider cleared
          if (tick && !gate_arm_flop) begin
            gate_time_divider <= at_end ? '0 : gate_time_divider + CNT_W'(1);
          end
          if (arm_clr_req) begin
            gate_arm_flop <= 1'b0;
          end
          if (arm_set_req) begin
            gate_arm_flop <= 1'b1;
            gate_sync_flop <= 1'b0;
            gate_time_divider <= '0;
            gate_done <= 1'b0;
            term_out <= 1'b0;
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (tick) begin
            gate_output_flop <= 1'b0;
          end
          if (arm_clr_req) begin
            gate_arm_flop <= 1'b0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tick && code_ok) begin
            gate_sync_flop <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick && gate_sync_flop) begin
            gate_output_flop <= 1'b1;
            gate_time_divider <= gate_time_divider + CNT_W'(1);
            if (gate_time_divider + CNT_W'(1) == half) begin
              term_out <= 1'b1;
            end
            if (at_end) begin
              term_out <= 1'b0;
              gate_arm_flop <= 1'b1;
              gate_sync_flop <= 1'b0;
              gate_time_divider <= '0;
            end
          end else if (tick && gate_arm_flop) begin
            gate_output_flop <= 1'b0;
            gate_done <= 1'b1;
            state <= ST_FREE;
          end
        end
        default: state <= ST_FREE;
      endcase
      if (!code_ok && state != ST_RUN) begin
        gate_output_flop <= 1'b0;
      end
    end
  end

  // arm left set after close; processor clears it via the clear bit
  always_comb chain_gate = gate_output_flop;

  ////////////////////////////////////////////////////////////////////////////
  // Gate steps; each but the invalid-code check is checked on the tick that causes it, not on wall time
  sequence s_release;
    state == ST_WAIT && tick && code_ok;
  endsequence
  sequence s_sync_running;
    state == ST_RUN && gate_sync_flop;
  endsequence
  sequence s_terminal;
    state == ST_RUN && gate_sync_flop && tick && at_end;
  endsequence
  sequence s_close_pending;
    state == ST_RUN && gate_arm_flop && !gate_sync_flop && gate_output_flop;
  endsequence
  property p_init_closes;
    @(posedge pclk) disable iff (!presetn)
      state == ST_INIT && tick |=> !gate_output_flop;
  endproperty
  a_init_closes: assert property (p_init_closes)
    else $error("gate not closed on first tick after arming");
  property p_sync_after_release;
    @(posedge pclk) disable iff (!presetn)
      s_release |=> s_sync_running;
  endproperty
  a_sync_after_release: assert property (p_sync_after_release)
    else $error("sync flop not set on tick after release");
  property p_open_on_tick;
    @(posedge pclk) disable iff (!presetn)
      s_sync_running ##0 tick |=> gate_output_flop;
  endproperty
  a_open_on_tick: assert property (p_open_on_tick)
    else $error("gate not open while sync flop set");
  // Holds for every ratio of two or more, so for all valid codes
  property p_half_high;
    @(posedge pclk) disable iff (!presetn)
      s_terminal |-> term_out;
  endproperty
  a_half_high: assert property (p_half_high)
    else $error("terminal output not high in second half of gate");
  property p_terminal;
    @(posedge pclk) disable iff (!presetn)
      s_terminal |=> s_close_pending ##0 !term_out;
  endproperty
  a_terminal: assert property (p_terminal)
    else $error("terminal count did not set arm and clear sync");
  property p_close;
    @(posedge pclk) disable iff (!presetn)
      s_close_pending ##0 tick |=> state == ST_FREE && gate_done && !gate_output_flop;
  endproperty
  a_close: assert property (p_close)
    else $error("gate not closed on tick after terminal count");
  property p_invalid_no_sync;
    @(posedge pclk) disable iff (!presetn)
      state == ST_WAIT && !code_ok |=> !gate_sync_flop && !gate_output_flop;
  endproperty
  a_invalid_no_sync: assert property (p_invalid_no_sync)
    else $error("gate started with invalid code");
endmodule

// File: gate_gen_regs.svh
`ifndef GATE_GEN_REGS_SVH
`define GATE_GEN_REGS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define CTRL_SEL_BIT 0
`define CTRL_ARM_SET_BIT 1
`define CTRL_ARM_CLR_BIT 2
`define CTRL_GT_LSB 4
`define CTRL_GT_MSB 6
`define ST_GATE_BIT 0
`define ST_ARM_BIT 1
`define ST_SYNC_BIT 2
`define ST_TERM_BIT 3
`define ST_DONE_BIT 4
`define PRESCALE_DECADE 4'h9
`define GT_CODE_MIN 3'h1
`define GT_CODE_MAX 3'h5
`define GT_RATIO_1 32'h0000000A
`define GT_RATIO_2 32'h00000064
`define GT_RATIO_3 32'h000003E8
`define GT_RATIO_4 32'h00002710
`define GT_RATIO_5 32'h000186A0
`define CTRL_SEL_RESET 1'b1
`define CTRL_GT_RESET 3'h1
`endif

// File: gate_gen_pkg.sv
package gate_gen_pkg;
  typedef enum logic [1:0] {
    ST_FREE = 2'b00,
    ST_INIT = 2'b01,
    ST_WAIT = 2'b10,
    ST_RUN = 2'b11
  } gate_state_t;
  typedef logic [2:0] gate_code_t;
endpackage

// File: tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic tick_10m;
  logic tick_100k;
  modport src (output tick_10m, output tick_100k);
  modport dst (input tick_10m, input tick_100k);
endinterface

// File: reference_prescaler.sv
`timescale 1ns/1ps
`include "gate_gen_regs.svh"
module reference_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selected reference edge
  input wire logic ref_edge,
  // Ticks out
  tick_if.src ticks
);
  logic [3:0] units;
  logic [3:0] tens;
  wire units_wrap = ref_edge && (units == `PRESCALE_DECADE);
  wire tens_wrap = units_wrap && (tens == `PRESCALE_DECADE);
  assign ticks.tick_10m = ref_edge;
  assign ticks.tick_100k = tens_wrap;
  // Two cascaded decades give divide by 100
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units <= 4'h0;
      tens <= 4'h0;
    end else if (ref_edge) begin
      units <= units_wrap ? 4'h0 : units + 4'h1;
      if (units_wrap) begin
        tens <= tens_wrap ? 4'h0 : tens + 4'h1;
      end
    end
  end
endmodule

// File: ref_source_model.sv
`timescale 1ns/1ps
module ref_source_model (
  // Clock
  input wire logic pclk,
  // Oscillator control and shared reference line
  input wire logic int_run,
  input wire logic line_oe,
  input wire logic line_out,
  output logic internal_ref,
  output logic line_in,
  // Count chain side
  input wire logic conv_clk,
  input wire logic gate,
  output logic [31:0] len,
  output logic [31:0] edges
);
  logic ext_ref = 1'b0;
  logic conv_q = 1'b0;
  logic [31:0] run = 0;
  logic [31:0] run_e = 0;
  initial begin
    internal_ref = 1'b0;
    len = 0;
    edges = 0;
  end
  // Oscillator off stands still so a wrong path selection starves the prescaler
  always @(posedge pclk) begin
    internal_ref <= int_run ? !internal_ref : 1'b0;
    ext_ref <= !int_run ? !ext_ref : 1'b0;
  end
  // Device drives the shared line only while enabled
  assign line_in = line_oe ? line_out : ext_ref;
  // Gate length in pclk cycles and converter edges inside the gate
  always @(posedge pclk) begin
    conv_q <= conv_clk;
    if (gate) begin
      run <= run + 1;
      run_e <= run_e + 32'(conv_clk && !conv_q);
    end else if (run != 0) begin
      len <= run;
      edges <= run_e;
      // Stages cleared before the next gated count
      run <= 0;
      run_e <= 0;
    end
  end
endmodule

// File: reference_select_gate_generator_test.sv
`timescale 1ns/1ps
`include "gate_gen_regs.svh"
module reference_select_gate_generator_test;
  logic pclk, presetn, psel, penable, pwrite, int_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, len, edges;
  logic pready, pslverr, e, iref, lin, lout, loe, ipe, epe, conv, tick, gate;
  int miscompares = 0;
  int check_count = 0;
  reference_select_gate_generator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_ref(iref), .reference_io_line_in(lin),
    .reference_io_line_out(lout), .reference_io_line_oe(loe), .internal_path_en(ipe),
    .external_path_en(epe), .converter_clock_output(conv), .chain_ref_100k(tick),
    .chain_gate(gate));
  ref_source_model far (.pclk(pclk), .int_run(int_run), .line_oe(loe), .line_out(lout),
    .internal_ref(iref), .line_in(lin), .conv_clk(conv), .gate(gate), .len(len),
    .edges(edges));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t %s got %h", $time, msg, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Zero wait states expected, but no latency is assumed
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("unexpected %0t no ready on bus", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_gate(input logic lvl);
    int n;
    n = 0;
    while (gate !== lvl && n < 30000) begin
      @(posedge pclk);
      n++;
    end
    if (gate !== lvl) begin
      miscompares++;
      $display("unexpected %0t gate stuck", $time);
    end
  endtask
  // High samples of line drive, converter clock and 100 kHz over two tick periods
  task automatic sample(output int n_out, output int n_conv, output int n_tick);
    n_out = 0;
    n_conv = 0;
    n_tick = 0;
    repeat (400) begin
      @(posedge pclk);
      n_out += int'(lout === 1'b1);
      n_conv += int'(conv === 1'b1);
      n_tick += int'(tick === 1'b1);
    end
  endtask
  // Arm, release, then measure one gate; ratio in 100 kHz periods
  task automatic meas(input logic sel, input logic [2:0] code, input int ratio);
    apb(1'b1, `ADDR_CTRL, {25'h0, code, 3'h1, sel});
    apb(1'b1, `ADDR_CTRL, {25'h0, code, 3'h2, sel});
    wait_gate(1'b1);
    wait_gate(1'b0);
    repeat (2) @(posedge pclk);
    chk(len, 32'(ratio * 200), "gate length");
    chk(edges, 32'(ratio * 100), "converter edges");
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk({27'h0, r[4:0]}, 32'h12, "status after close");
    apb(1'b1, `ADDR_CTRL, {25'h0, code, 3'h2, sel});
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(r, 32'h10, "status after arm clear");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = !pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    int hi, n_out, n_conv, n_tick;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    int_run = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk({30'h0, gate, r[1]}, 32'h0, "idle after reset");
    apb(1'b0, 12'h008, 32'h0);
    chk({e, r[30:0]}, 32'h80000000, "unmapped read");
    chk({ipe, epe, loe}, 32'h5, "internal mode paths");
    sample(n_out, n_conv, n_tick);
    chk(32'(n_out), 32'hC8, "line drive internal");
    chk(32'(n_conv), 32'hC8, "converter clock internal");
    chk(32'(n_tick), 32'h2, "100 kHz pulses internal");
    meas(1'b1, 3'h1, 10);
    meas(1'b1, 3'h2, 100);
    int_run <= 1'b0;
    meas(1'b0, 3'h1, 10);
    chk({ipe, epe, loe}, 32'h2, "external mode paths");
    sample(n_out, n_conv, n_tick);
    chk(32'(n_out), 32'h0, "line drive external");
    chk(32'(n_conv), 32'hC8, "converter clock external");
    chk(32'(n_tick), 32'h2, "100 kHz pulses external");
    int_run <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 32'h3);
    apb(1'b1, `ADDR_CTRL, 32'h5);
    hi = 0;
    repeat (3000) begin
      @(posedge pclk);
      hi += int'(gate === 1'b1);
    end
    chk(32'(hi), 32'h0, "gate with invalid code");
    print_verdict();
  end
endmodule
